/* File: core/trigger_control_regs.svh */
`ifndef TRIGGER_CONTROL_REGS_SVH
`define TRIGGER_CONTROL_REGS_SVH
// program code encodings on the command port
`define CODE_W             3
`define CODE_HOLD          3'h0
`define CODE_IMMEDIATE     3'h1
`define CODE_DELAYED       3'h2
`define CODE_CONTINUOUS    3'h3
`define CODE_OTHER         3'h4
// settling delay before a delayed trigger, in ns
`define SETTLE_NS          2000
`define CLK_PERIOD_NS      8
`define SETTLE_CYCLES      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_W           16
`define STATUS_READY_BIT   0
`endif

/* File: core/trigger_control_pkg.sv */
package trigger_control_pkg;
  typedef struct packed {
    logic       valid;
    logic [2:0] code;
  } command_t;

  typedef enum logic [4:0] {
    S_RUN    = 5'b0_0001,
    S_IDLE   = 5'b0_0010,
    S_SETTLE = 5'b0_0100,
    S_MEAS   = 5'b0_1000,
    S_HELD   = 5'b1_0000
  } trig_state_t;
endpackage : trigger_control_pkg

/* File: core/settle_timer.sv */
`timescale 1ns/10ps
`include "trigger_control_regs.svh"
module settle_timer #(
  parameter int CYCLES = `SETTLE_CYCLES
) (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  input  wire logic start_i,
  input  wire logic cancel_i,
  output logic      done_o
);
  localparam int CW = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("settle_timer: CYCLES must be at least 1");
  end
  logic [CW-1:0] count;
  logic          busy;
  wire           last = busy && (count == CW'(1));
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || cancel_i) begin
      count  <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last;
      if (start_i) begin
        count <= CW'(CYCLES);
        busy  <= 1'b1;
      end else if (busy) begin
        count <= count - CW'(1);
        busy  <= !last;
      end
    end
  end
endmodule : settle_timer

/* File: core/measurement_trigger_control.sv */
`timescale 1ns/10ps
`include "trigger_control_regs.svh"
module measurement_trigger_control
  import trigger_control_pkg::*;
#(
  parameter int RESULT_W      = `RESULT_W,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input  wire logic                CLK_I,
  input  wire logic                RST_N_I,
  input  wire command_t            CMD_I,
  input  wire logic                GROUP_TRIGGER_I,
  input  wire logic                RESULT_READ_I,
  input  wire logic                REMOTE_I,
  input  wire logic                LOCAL_KEY_I,
  input  wire logic                SAMPLE_VALID_I,
  input  wire logic [RESULT_W-1:0] SAMPLE_I,
  output logic                     FILTER_CLEAR_O,
  output logic                     DISPLAY_UPDATE_O,
  output logic [RESULT_W-1:0]      DISPLAY_VALUE_O,
  output logic [RESULT_W-1:0]      BUS_RESULT_O,
  output logic                     DATA_READY_O,
  output logic                     STANDBY_O,
  output logic                     SETTINGS_WRITE_O,
  output logic [7:0]               STATUS_BYTE_O
);
  initial begin
    if (RESULT_W < 1) $error("RESULT_W must be at least 1");
    if (SETTLE_CYCLES < 1) $error("SETTLE_CYCLES must be at least 1");
  end

  // panel and remote-enable levels come from outside the clock domain
  logic remote_meta, remote_sync, key_meta, key_sync, key_prev;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      remote_meta <= 1'b0;
      remote_sync <= 1'b0;
      key_meta    <= 1'b0;
      key_sync    <= 1'b0;
      key_prev    <= 1'b0;
    end else begin
      remote_meta <= REMOTE_I;
      remote_sync <= remote_meta;
      key_meta    <= LOCAL_KEY_I;
      key_sync    <= key_meta;
      key_prev    <= key_sync;
    end
  end

  trig_state_t state, next_state;
  logic        armed_done;

  // decode
  wire key_press   = key_sync && !key_prev;
  wire go_local    = key_press || !remote_sync;
  wire cmd_ok      = CMD_I.valid && remote_sync;
  wire is_hold     = cmd_ok && (CMD_I.code == `CODE_HOLD);
  wire is_imm      = cmd_ok && (CMD_I.code == `CODE_IMMEDIATE);
  wire is_dly      = cmd_ok && (CMD_I.code == `CODE_DELAYED);
  wire is_run      = cmd_ok && (CMD_I.code == `CODE_CONTINUOUS);
  wire is_setting  = cmd_ok && !is_hold && !is_imm && !is_dly && !is_run;
  wire get_ok      = GROUP_TRIGGER_I && remote_sync;
  wire in_run      = (state == S_RUN);
  wire busy_trig   = (state == S_SETTLE) || (state == S_MEAS);
  wire start_timer = (is_dly || (get_ok && state == S_SETTLE)) && !go_local;
  wire cancel      = go_local || is_run || is_hold || is_setting && busy_trig;
  wire publish_run = in_run && SAMPLE_VALID_I;
  wire publish_trg = (state == S_MEAS) && SAMPLE_VALID_I;
  wire read_done   = (state == S_HELD) && RESULT_READ_I;

  settle_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .CLK_I    (CLK_I),
    .RST_N_I  (RST_N_I),
    .start_i  (start_timer),
    .cancel_i (cancel),
    .done_o   (armed_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (is_imm) next_state = S_MEAS;
        else if (is_dly) next_state = S_SETTLE;
        else if (is_hold) next_state = S_IDLE;
      end
      S_IDLE: begin
        if (is_imm || get_ok) next_state = S_MEAS;
        else if (is_dly) next_state = S_SETTLE;
        else if (is_run) next_state = S_RUN;
      end
      S_SETTLE, S_MEAS: begin
        if (is_run) next_state = S_RUN;
        else if (is_hold || is_setting) next_state = S_IDLE;
        else if (is_imm || get_ok) next_state = S_MEAS;
        else if (is_dly) next_state = S_SETTLE;
        else if (state == S_SETTLE && armed_done) next_state = S_MEAS;
        else if (publish_trg) next_state = S_HELD;
      end
      S_HELD: begin
        if (is_run) next_state = S_RUN;
        else if (read_done) next_state = S_IDLE;
        else if (is_imm || get_ok) next_state = S_MEAS;
        else if (is_dly) next_state = S_SETTLE;
        else if (is_hold) next_state = S_IDLE;
        // other commands leave the held result alone
      end
      default: next_state = S_RUN;
    endcase
    if (go_local) next_state = S_RUN;
  end

  // a trigger leaving the held state drops its result from the status byte
  wire ready_set = publish_trg && next_state == S_HELD;
  wire ready_clr = !in_run && (read_done || (state == S_HELD && next_state != S_HELD));
  wire publish    = publish_run || publish_trg;
  // status byte follows the next ready value so both change on one edge
  wire next_ready = ready_set || (DATA_READY_O && !ready_clr);

  // trigger state
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= S_RUN;
    end else begin
      state <= next_state;
    end
  end

  // mode flag, registered from the next state so it never lags the state
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      STANDBY_O <= 1'b0;
    end else begin
      STANDBY_O <= (next_state != S_RUN);
    end
  end

  // trigger paths never clear the filter
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FILTER_CLEAR_O <= 1'b0;
    end else begin
      FILTER_CLEAR_O <= 1'b0;
    end
  end

  // settings pass through in standby as well
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SETTINGS_WRITE_O <= 1'b0;
    end else begin
      SETTINGS_WRITE_O <= is_setting;
    end
  end

  // one pulse per published measurement
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DISPLAY_UPDATE_O <= 1'b0;
    end else begin
      DISPLAY_UPDATE_O <= publish;
    end
  end

  // display and bus copies always carry the same value
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DISPLAY_VALUE_O <= '0;
      BUS_RESULT_O    <= '0;
    end else if (publish) begin
      DISPLAY_VALUE_O <= SAMPLE_I;
      BUS_RESULT_O    <= SAMPLE_I;
    end
  end

  // set wins over clear; in continuous the bit is frozen
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DATA_READY_O <= 1'b0;
    end else if (ready_set) begin
      DATA_READY_O <= 1'b1;
    end else if (ready_clr) begin
      DATA_READY_O <= 1'b0;
    end
  end

  // only the ready bit is owned here; the rest of the byte reads zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      STATUS_BYTE_O <= 8'h00;
    end else begin
      STATUS_BYTE_O                    <= 8'h00;
      STATUS_BYTE_O[`STATUS_READY_BIT] <= next_ready;
    end
  end
endmodule : measurement_trigger_control

/* File: tb/trig_ctl_asserts.sv */
`timescale 1ns/10ps
`include "trigger_control_regs.svh"
module trig_ctl_asserts
  import trigger_control_pkg::*;
#(
  parameter int RESULT_W      = 16,
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic                CLK_I,
  input wire logic                RST_N_I,
  input wire command_t            CMD_I,
  input wire logic                GROUP_TRIGGER_I,
  input wire logic                RESULT_READ_I,
  input wire logic                REMOTE_I,
  input wire logic                LOCAL_KEY_I,
  input wire logic                SAMPLE_VALID_I,
  input wire logic [RESULT_W-1:0] SAMPLE_I,
  input wire logic                FILTER_CLEAR_O,
  input wire logic                DISPLAY_UPDATE_O,
  input wire logic [RESULT_W-1:0] DISPLAY_VALUE_O,
  input wire logic [RESULT_W-1:0] BUS_RESULT_O,
  input wire logic                DATA_READY_O,
  input wire logic                STANDBY_O,
  input wire logic                SETTINGS_WRITE_O,
  input wire logic [7:0]          STATUS_BYTE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // remote must have settled through the synchroniser before codes count
  sequence s_rem; REMOTE_I && $past(REMOTE_I, 3) && $past(RST_N_I, 3); endsequence
  sequence s_dly; CMD_I.valid && CMD_I.code == `CODE_DELAYED && STANDBY_O; endsequence
  property p_clr; !FILTER_CLEAR_O; endproperty
  a_clr: assert property (p_clr) else $error("filter cleared");
  property p_sts; STATUS_BYTE_O == {7'h00, DATA_READY_O}; endproperty
  a_sts: assert property (p_sts) else $error("status byte mismatch");
  property p_pub; DISPLAY_UPDATE_O |-> $past(SAMPLE_VALID_I)
    && DISPLAY_VALUE_O == $past(SAMPLE_I) && BUS_RESULT_O == DISPLAY_VALUE_O; endproperty
  a_pub: assert property (p_pub) else $error("bad publish");
  property p_run; !STANDBY_O && SAMPLE_VALID_I && !CMD_I.valid |=> DISPLAY_UPDATE_O; endproperty
  a_run: assert property (p_run) else $error("sample not published");
  property p_frz; !STANDBY_O ##1 !STANDBY_O |-> $stable(DATA_READY_O); endproperty
  a_frz: assert property (p_frz) else $error("ready moved in run mode");
  property p_stb; CMD_I.valid && CMD_I.code inside {`CODE_HOLD, `CODE_IMMEDIATE,
    `CODE_DELAYED} ##0 s_rem |=> STANDBY_O; endproperty
  a_stb: assert property (p_stb) else $error("standby not entered");
  property p_cont; CMD_I.valid && CMD_I.code == `CODE_CONTINUOUS ##0 s_rem |=> !STANDBY_O;
  endproperty
  a_cont: assert property (p_cont) else $error("run mode not entered");
  property p_rd; DATA_READY_O && STANDBY_O && RESULT_READ_I && !SAMPLE_VALID_I
    && !CMD_I.valid && !GROUP_TRIGGER_I |=> !DATA_READY_O && STANDBY_O; endproperty
  a_rd: assert property (p_rd) else $error("read did not clear");
  property p_settle; s_dly |=> !DISPLAY_UPDATE_O [*4]; endproperty
  a_settle: assert property (p_settle) else $error("publish inside settle");
endmodule : trig_ctl_asserts

/* File: tb/bus_ctl_model.sv */
`timescale 1ns/10ps
module bus_ctl_model
  import trigger_control_pkg::*;
(
  input  wire logic clk_i,
  output command_t  cmd_o,
  output logic      get_o,
  output logic      read_o
);
  initial cmd_o = '0;
  initial get_o = 1'b0;
  initial read_o = 1'b0;
  // strobes last one cycle; a gap cycle keeps two strobes apart
  task send(input logic [2:0] c);
    @(posedge clk_i) cmd_o <= '{1'b1, c};
    @(posedge clk_i) cmd_o <= '0;
  endtask : send
  task pulse_get;
    @(posedge clk_i) get_o <= 1'b1;
    @(posedge clk_i) get_o <= 1'b0;
  endtask : pulse_get
  task pulse_read;
    @(posedge clk_i) read_o <= 1'b1;
    @(posedge clk_i) read_o <= 1'b0;
  endtask : pulse_read
endmodule : bus_ctl_model

/* File: tb/measurement_trigger_control_tb.sv */
`timescale 1ns/10ps
`include "trigger_control_regs.svh"
module measurement_trigger_control_tb;
  import trigger_control_pkg::*;
  typedef struct {logic [2:0] c; logic pub; logic stb;} row_t;
  logic        clk = 0, rst_n = 0, rem = 0, lkey = 0, sv = 0;
  logic [15:0] smp = 16'h0000, dv, br, ex;
  logic        fc, du, dr, sb, sw, get, rd;
  logic [7:0]  sts;
  command_t    cmd;
  int          fails = 0, n_checks = 0;
  row_t rows[6] = '{'{`CODE_CONTINUOUS, 1, 0}, '{`CODE_IMMEDIATE, 1, 1}, '{`CODE_HOLD, 0, 1},
    '{`CODE_DELAYED, 1, 1}, '{`CODE_OTHER, 0, 1}, '{`CODE_CONTINUOUS, 1, 0}};
  always #4 clk = ~clk;
  bus_ctl_model bus_ctl_model_inst (.clk_i(clk), .cmd_o(cmd), .get_o(get), .read_o(rd));
  measurement_trigger_control #(.SETTLE_CYCLES(4)) measurement_trigger_control_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .CMD_I(cmd), .GROUP_TRIGGER_I(get), .RESULT_READ_I(rd),
    .REMOTE_I(rem), .LOCAL_KEY_I(lkey), .SAMPLE_VALID_I(sv), .SAMPLE_I(smp),
    .FILTER_CLEAR_O(fc), .DISPLAY_UPDATE_O(du), .DISPLAY_VALUE_O(dv), .BUS_RESULT_O(br),
    .DATA_READY_O(dr), .STANDBY_O(sb), .SETTINGS_WRITE_O(sw), .STATUS_BYTE_O(sts));
  task chk(input logic [15:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task sample(input logic [15:0] v);
    @(posedge clk) begin
      sv <= 1'b1;
      smp <= v;
    end
    @(posedge clk) sv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : sample
  task stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    ex = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rem <= 1'b1;
    repeat (4) @(posedge clk);
    chk(dv, 16'h0000, "reset value");
    chk(16'(sb), 16'h0000, "reset mode");
    foreach (rows[i]) begin
      bus_ctl_model_inst.send(rows[i].c);
      repeat (8) @(posedge clk);
      sample(16'h1000 + 16'(i));
      if (rows[i].pub) ex = 16'h1000 + 16'(i);
      chk(dv, ex, "display");
      chk(br, ex, "bus result");
      chk(16'(sb), 16'(rows[i].stb), "mode");
      chk(16'(dr), 16'(rows[i].pub & rows[i].stb), "ready");
      bus_ctl_model_inst.pulse_read();
      @(posedge clk);
      chk(16'(dr), 16'h0000, "ready after read");
      chk(16'(sb), 16'(rows[i].stb), "mode after read");
      $display("row %0d done", i);
    end
    bus_ctl_model_inst.send(`CODE_IMMEDIATE);
    bus_ctl_model_inst.send(`CODE_OTHER);
    @(negedge clk);
    chk(16'(sw), 16'h0001, "setting write");
    sample(16'h2000);
    chk(dv, ex, "aborted trigger");
    chk(16'(dr), 16'h0000, "no ready on abort");
    $display("abort test done");
    bus_ctl_model_inst.send(`CODE_IMMEDIATE);
    bus_ctl_model_inst.pulse_get();
    sample(16'h3000);
    chk(dv, 16'h3000, "fresh cycle");
    bus_ctl_model_inst.send(`CODE_OTHER);
    @(negedge clk);
    chk(16'(dr), 16'h0001, "held kept");
    chk(16'(sts), 16'h0001, "status ready");
    bus_ctl_model_inst.pulse_read();
    $display("group trigger test done");
    @(posedge clk) lkey <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(sb), 16'h0000, "local key");
    sample(16'h4000);
    chk(dv, 16'h4000, "refresh on leave");
    @(posedge clk) rem <= 1'b0;
    repeat (4) @(posedge clk);
    bus_ctl_model_inst.send(`CODE_IMMEDIATE);
    repeat (2) @(posedge clk);
    chk(16'(sb), 16'h0000, "panel ignores code");
    $display("local test done");
    stop_test();
  end
  initial begin
    #100us;
    fails++;
    stop_test();
  end
endmodule : measurement_trigger_control_tb
bind measurement_trigger_control trig_ctl_asserts #(.RESULT_W(RESULT_W),
  .SETTLE_CYCLES(SETTLE_CYCLES)) trig_ctl_asserts_inst (.CLK_I, .RST_N_I, .CMD_I,
  .GROUP_TRIGGER_I, .RESULT_READ_I, .REMOTE_I, .LOCAL_KEY_I, .SAMPLE_VALID_I, .SAMPLE_I,
  .FILTER_CLEAR_O, .DISPLAY_UPDATE_O, .DISPLAY_VALUE_O, .BUS_RESULT_O, .DATA_READY_O,
  .STANDBY_O, .SETTINGS_WRITE_O, .STATUS_BYTE_O);
